// File: tfc_map.vh
// register map, reset values and field positions of the fan config bank
// Function
// - round-robin bit 7 of cfg2 cycles both channels; 0 gives single channel; resets 1.
// - single channel: selector bit 4 picks local at 0, remote at 1.
// - cfg2 bit 2 selects linear speed law at 1 (reset), discrete at 0.
// - boost-inhibit bit 1 stops boost on thermal limits; fan keeps last speed.
// - writing 1 to cfg2 bit 0 restores defaults, then the bit self-clears.
// - cfg3 bits 3:0 hold fan pole count, reset 4; even counts advised.
// - cfg4 bit 7 picks pin function: 0 fan failure out, 1 reference in.
// - cfg4 bits 6:4 set duty window 0.25 s doubling to 8 s; 110,111 = 8 s.
// - cfg4 bit 3 at 1 enables the exclusive-or connectivity test.
// - cfg4 bit 1 with timer enabled drives thermal line on remote overtemp.
// - cfg4 bit 0 with timer enabled drives thermal line on local overtemp.
// - rate bits 3:0 pick 0.0625 per second doubling to 64 at code 1010.
// - a written rate code takes effect at the next round-robin start; a restore applies 0x0A at once.
// - rate register loads 0x0A at power-on and restore, obeys the lock.
// - thermal timer enable in cfg1 gates both event enables; resets 0.
// - while lock bit is 1, host writes to these registers are ignored.
`ifndef TFC_MAP_VH
`define TFC_MAP_VH
`define TFC_ADDR_CFG2 8'h02
`define TFC_ADDR_CFG3 8'h03
`define TFC_ADDR_CFG4 8'h04
`define TFC_ADDR_RATE 8'h05
`define TFC_RST_CFG2 8'h84
`define TFC_RST_CFG3 8'h44
`define TFC_RST_CFG4 8'h00
`define TFC_RST_RATE 8'h0A
`define TFC_RATE_MASK 8'h8F
`define TFC_CFG2_MASK 8'hFE
`define TFC_B_ROUND 7
`define TFC_B_CHAN 4
`define TFC_B_LAW 2
`define TFC_B_BOOST 1
`define TFC_B_RESTORE 0
`define TFC_B_PIN 7
`define TFC_F_WIN_HI 6
`define TFC_F_WIN_LO 4
`define TFC_B_XOR 3
`define TFC_B_REMEV 1
`define TFC_B_LOCEV 0
`define TFC_F_POLE_HI 3
`define TFC_F_RATE_HI 3
`define TFC_WIN_MAX 3'h5
`define TFC_RATE_MAX 4'hA
`endif

// File: tfc_config_regs.v
// configuration register bank of the thermal monitor and fan controller
`timescale 1ns/10ps
`include "tfc_map.vh"
module tfc_config_regs (
	clk_sys,
	rst,
	clk_en,
	reg_addr,
	reg_wr,
	reg_wdata,
	reg_rd,
	reg_rdata_q,
	lock_bit,
	hot_duty_fraction_timer_en,
	local_over_limit,
	remote_over_limit,
	boost_request,
	round_start,
	round_robin_q,
	chan_remote_q,
	speed_law_linear_q,
	fan_boost_q,
	software_restore_q,
	pole_count_q,
	pin_is_ref_q,
	hot_duty_window_q,
	xor_test_q,
	thermal_limit_line_out_q,
	thermal_limit_line_oe_n_q,
	rate_code_q
);
	input clk_sys;
	input rst;
	input clk_en;
	input [7:0] reg_addr;
	input reg_wr;
	input [7:0] reg_wdata;
	input reg_rd;
	output reg [7:0] reg_rdata_q;
	input lock_bit;
	input hot_duty_fraction_timer_en;
	input local_over_limit;
	input remote_over_limit;
	input boost_request;
	input round_start;
	output reg round_robin_q;
	output reg chan_remote_q;
	output reg speed_law_linear_q;
	output reg fan_boost_q;
	output reg software_restore_q;
	output reg [3:0] pole_count_q;
	output reg pin_is_ref_q;
	output reg [2:0] hot_duty_window_q;
	output reg xor_test_q;
	output reg thermal_limit_line_out_q;
	output reg thermal_limit_line_oe_n_q;
	output reg [3:0] rate_code_q;

	reg [7:0] cfg2_q;
	reg [7:0] cfg3_q;
	reg [7:0] cfg4_q;
	reg [7:0] rate_q;
	reg [7:0] cfg2_d;
	reg [7:0] cfg3_d;
	reg [7:0] cfg4_d;
	reg [7:0] rate_d;
	reg [7:0] rdata_d;
	reg restore_d;
	reg hot_duty_fraction_drive_d;
	wire wr_ok;

	// reset images, so mirror outputs start from the same documented values
	localparam [7:0] RST2 = `TFC_RST_CFG2;
	localparam [7:0] RST3 = `TFC_RST_CFG3;
	localparam [7:0] RST4 = `TFC_RST_CFG4;
	localparam [7:0] RSTR = `TFC_RST_RATE;

	// clamp a window code: codes above 8 s select 8 s
	function [2:0] win_clamp;
		input [2:0] code;
		begin
			if (code > `TFC_WIN_MAX) begin
				win_clamp = `TFC_WIN_MAX;
			end else begin
				win_clamp = code;
			end
		end
	endfunction

	// clamp a rate code to the fastest defined rate
	function [3:0] rate_clamp;
		input [3:0] code;
		begin
			if (code > `TFC_RATE_MAX) begin
				rate_clamp = `TFC_RATE_MAX;
			end else begin
				rate_clamp = code;
			end
		end
	endfunction

	assign wr_ok = reg_wr & ~lock_bit;

	always @* begin
		cfg2_d = cfg2_q;
		cfg3_d = cfg3_q;
		cfg4_d = cfg4_q;
		rate_d = rate_q;
		restore_d = 1'b0;
		if (wr_ok) begin
			case (reg_addr)
			`TFC_ADDR_CFG2: begin
				// restore bit is not stored, so it reads back 0
				cfg2_d = reg_wdata & `TFC_CFG2_MASK;
				restore_d = reg_wdata[`TFC_B_RESTORE];
			end
			`TFC_ADDR_CFG3: begin
				cfg3_d = reg_wdata;
			end
			`TFC_ADDR_CFG4: begin
				cfg4_d = reg_wdata;
			end
			`TFC_ADDR_RATE: begin
				rate_d = reg_wdata & `TFC_RATE_MASK;
			end
			default: begin
				cfg2_d = cfg2_q;
			end
			endcase
		end
		if (restore_d) begin
			cfg2_d = `TFC_RST_CFG2;
			cfg3_d = `TFC_RST_CFG3;
			cfg4_d = `TFC_RST_CFG4;
			rate_d = `TFC_RST_RATE;
		end
	end

	always @* begin
		case (reg_addr)
		`TFC_ADDR_CFG2: begin
			rdata_d = cfg2_q;
		end
		`TFC_ADDR_CFG3: begin
			rdata_d = cfg3_q;
		end
		`TFC_ADDR_CFG4: begin
			rdata_d = cfg4_q;
		end
		`TFC_ADDR_RATE: begin
			rdata_d = rate_q & `TFC_RATE_MASK;
		end
		default: begin
			rdata_d = 8'h00;
		end
		endcase
	end

	// both event enables depend on the thermal timer being on
	always @* begin
		hot_duty_fraction_drive_d = hot_duty_fraction_timer_en & (
			(cfg4_q[`TFC_B_REMEV] & remote_over_limit) |
			(cfg4_q[`TFC_B_LOCEV] & local_over_limit));
	end

	// measurement and fan mode register
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg2_q <= `TFC_RST_CFG2;
		end else if (clk_en) begin
			cfg2_q <= cfg2_d;
		end
	end

	// fan pole register
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg3_q <= `TFC_RST_CFG3;
		end else if (clk_en) begin
			cfg3_q <= cfg3_d;
		end
	end

	// pin and event register
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg4_q <= `TFC_RST_CFG4;
		end else if (clk_en) begin
			cfg4_q <= cfg4_d;
		end
	end

	// rate register as the host sees it
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rate_q <= `TFC_RST_RATE;
		end else if (clk_en) begin
			rate_q <= rate_d;
		end
	end

	// read data holds between read strobes
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
		end else if (clk_en) begin
			if (reg_rd) begin
				reg_rdata_q <= rdata_d;
			end
		end
	end

	// one-cycle pulse tells the other banks to restore as well
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			software_restore_q <= 1'b0;
		end else if (clk_en) begin
			software_restore_q <= restore_d;
		end
	end

	// rate only moves on a round start or a full restore
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rate_code_q <= RSTR[`TFC_F_RATE_HI:0];
		end else if (clk_en) begin
			if (restore_d) begin
				rate_code_q <= RSTR[`TFC_F_RATE_HI:0];
			end else if (round_start) begin
				rate_code_q <= rate_clamp(rate_q[`TFC_F_RATE_HI:0]);
			end
		end
	end

	// channel sequencing mirrors
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			round_robin_q <= RST2[`TFC_B_ROUND];
			chan_remote_q <= RST2[`TFC_B_CHAN];
		end else if (clk_en) begin
			round_robin_q <= cfg2_q[`TFC_B_ROUND];
			chan_remote_q <= cfg2_q[`TFC_B_CHAN];
		end
	end

	// fan speed law and boost gating
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			speed_law_linear_q <= RST2[`TFC_B_LAW];
			fan_boost_q <= 1'b0;
		end else if (clk_en) begin
			speed_law_linear_q <= cfg2_q[`TFC_B_LAW];
			fan_boost_q <= boost_request & ~cfg2_q[`TFC_B_BOOST];
		end
	end

	// pole count for the speed measurement
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pole_count_q <= RST3[`TFC_F_POLE_HI:0];
		end else if (clk_en) begin
			pole_count_q <= cfg3_q[`TFC_F_POLE_HI:0];
		end
	end

	// pin function and connectivity test
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_is_ref_q <= RST4[`TFC_B_PIN];
			xor_test_q <= RST4[`TFC_B_XOR];
		end else if (clk_en) begin
			pin_is_ref_q <= cfg4_q[`TFC_B_PIN];
			xor_test_q <= cfg4_q[`TFC_B_XOR];
		end
	end

	// duty window, long codes folded onto the longest window
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hot_duty_window_q <= RST4[`TFC_F_WIN_HI:`TFC_F_WIN_LO];
		end else if (clk_en) begin
			hot_duty_window_q <= win_clamp(
				cfg4_q[`TFC_F_WIN_HI:`TFC_F_WIN_LO]);
		end
	end

	// open drain: the pin value is low once out of reset
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			thermal_limit_line_out_q <= 1'b1;
		end else if (clk_en) begin
			thermal_limit_line_out_q <= 1'b0;
		end
	end

	// enable low pulls the line, released otherwise
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			thermal_limit_line_oe_n_q <= 1'b1;
		end else if (clk_en) begin
			thermal_limit_line_oe_n_q <= ~hot_duty_fraction_drive_d;
		end
	end
endmodule

// File: tfc_host.sv
// host side model driving the register port of the fan config bank
`timescale 1ns/10ps
module tfc_host(input wire clk_sys, input wire [7:0] reg_rdata_q,
	output reg [7:0] reg_addr = 8'h00, output reg reg_wr = 1'b0,
	output reg reg_rd = 1'b0, output reg [7:0] reg_wdata = 8'h00);
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_sys);
			#1 reg_addr = a;
			reg_wdata = (a == 8'h05) ? (d & 8'h7F) : d;
			reg_wr = 1'b1;
			@(posedge clk_sys);
			#1 reg_wr = 1'b0;
			reg_wdata = ~reg_wdata;
		end
	endtask
	task rd(input [7:0] a, output [7:0] v);
		begin
			@(posedge clk_sys);
			#1 reg_addr = a;
			reg_rd = 1'b1;
			@(posedge clk_sys);
			#1 reg_rd = 1'b0;
			v = reg_rdata_q;
		end
	endtask
endmodule

// File: tfc_monitor.sv
// port assertions of the fan config bank
`timescale 1ns/10ps
module tfc_monitor(input wire clk_sys, rst, clk_en, reg_wr, reg_rd,
	lock_bit, round_start, hot_duty_fraction_timer_en, round_robin_q, chan_remote_q,
	software_restore_q, thermal_limit_line_oe_n_q,
	input wire [7:0] reg_addr, reg_wdata, reg_rdata_q,
	input wire [3:0] rate_code_q, input wire [2:0] hot_duty_window_q);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	wire rs = clk_en && reg_wr && !lock_bit && reg_addr == 8'h02 && reg_wdata[0];
	chk_restore_pulse: assert property (rs |=> software_restore_q)
		else $error("restore pulse missing");
	chk_restore_dflt: assert property (rs |=> ##1 round_robin_q)
		else $error("restore default lost");
	chk_lock_hold: assert property (lock_bit && reg_wr && reg_addr == 8'h02
		##1 !reg_wr |=> $stable(chan_remote_q))
		else $error("locked write landed");
	chk_rate_wait: assert property (!round_start && !rs
		|=> $stable(rate_code_q))
		else $error("rate changed early");
	chk_rate_max: assert property (rate_code_q <= 4'hA)
		else $error("rate above max");
	chk_win_max: assert property (hot_duty_window_q <= 3'h5)
		else $error("window above max");
	chk_timer_gate: assert property (!hot_duty_fraction_timer_en
		|=> thermal_limit_line_oe_n_q)
		else $error("line driven without timer");
	chk_rsvd_zero: assert property (reg_rd && reg_addr == 8'h05
		|=> reg_rdata_q[6:4] == 3'h0)
		else $error("reserved rate bits set");
	cover property (rs);
	cover property (round_start ##1 $changed(rate_code_q));
	cover property (!thermal_limit_line_oe_n_q);
endmodule
bind tfc_config_regs tfc_monitor tfc_monitor_i(.*);

// File: tfc_config_regs_test.sv
// self-checking bench of the fan config bank
`timescale 1ns/10ps
module tfc_config_regs_test;
	reg clk_sys = 0, rst = 1, lock_bit = 0, hot_duty_fraction_timer_en = 0;
	reg local_over_limit = 0, remote_over_limit = 0, boost_request = 0;
	reg round_start = 0;
	reg clk_en = 1;
	wire reg_wr, reg_rd, round_robin_q, chan_remote_q, speed_law_linear_q;
	wire fan_boost_q, software_restore_q, pin_is_ref_q, xor_test_q;
	wire thermal_limit_line_out_q, thermal_limit_line_oe_n_q;
	wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
	wire [3:0] pole_count_q, rate_code_q;
	wire [2:0] hot_duty_window_q;
	wire [15:0] mir = {software_restore_q, thermal_limit_line_out_q,
		thermal_limit_line_oe_n_q, round_robin_q, chan_remote_q,
		speed_law_linear_q, fan_boost_q, pin_is_ref_q, xor_test_q,
		hot_duty_window_q, pole_count_q};
	integer error_cnt = 0, compares = 0, cyc = 0;
	reg [7:0] v;
	tfc_config_regs tfc_config_regs_i(.*);
	tfc_host tfc_host_i(.*);
	initial forever #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt = error_cnt + 1;
			complete_run;
		end
	end
	task ck(input string n, input [15:0] s, input [15:0] e);
		begin
			compares = compares + 1;
			if (s !== e) begin
				error_cnt = error_cnt + 1;
				$display("BAD %s exp %h got %h", n, e, s);
			end
		end
	endtask
	task rk(input [7:0] a, input [7:0] e);
		begin
			tfc_host_i.rd(a, v);
			ck("rdata", {8'h00, v}, {8'h00, e});
		end
	endtask
	task w2;
		begin
			repeat (2) @(posedge clk_sys);
			#1;
		end
	endtask
	task pulse;
		begin
			round_start = 1;
			@(posedge clk_sys);
			#1 round_start = 0;
		end
	endtask
	task t_reset;
		begin
			rk(8'h02, 8'h84);
			rk(8'h03, 8'h44);
			rk(8'h04, 8'h00);
			rk(8'h05, 8'h0A);
			rk(8'h06, 8'h00);
			$display("reset test done");
		end
	endtask
	task t_fields;
		begin
			boost_request = 1;
			tfc_host_i.wr(8'h02, 8'h12);
			tfc_host_i.wr(8'h04, 8'hE8);
			tfc_host_i.wr(8'h03, 8'h06);
			w2;
			ck("mir", mir, 16'h29D6);
			tfc_host_i.wr(8'h02, 8'h84);
			w2;
			ck("mir", mir, 16'h37D6);
			$display("fields test done");
		end
	endtask
	task t_events;
		begin
			hot_duty_fraction_timer_en = 1;
			remote_over_limit = 1;
			tfc_host_i.wr(8'h04, 8'h01);
			w2;
			ck("mir", mir, 16'h3606);
			local_over_limit = 1;
			w2;
			ck("mir", mir, 16'h1606);
			hot_duty_fraction_timer_en = 0;
			w2;
			ck("mir", mir, 16'h3606);
			tfc_host_i.wr(8'h04, 8'h02);
			hot_duty_fraction_timer_en = 1;
			w2;
			ck("mir", mir, 16'h1606);
			hot_duty_fraction_timer_en = 0;
			$display("events test done");
		end
	endtask
	task t_rate;
		begin
			tfc_host_i.wr(8'h05, 8'hF3);
			rk(8'h05, 8'h03);
			ck("rate", {12'h000, rate_code_q}, 16'h000A);
			pulse;
			ck("rate", {12'h000, rate_code_q}, 16'h0003);
			tfc_host_i.wr(8'h05, 8'h0C);
			pulse;
			ck("rate", {12'h000, rate_code_q}, 16'h000A);
			$display("rate test done");
		end
	endtask
	task t_lock;
		begin
			lock_bit = 1;
			tfc_host_i.wr(8'h05, 8'h05);
			tfc_host_i.wr(8'h02, 8'h01);
			w2;
			ck("mir", mir, 16'h3606);
			rk(8'h05, 8'h0C);
			lock_bit = 0;
			tfc_host_i.wr(8'h02, 8'h01);
			ck("rst", {15'h0000, software_restore_q}, 16'h0001);
			@(posedge clk_sys);
			#1 ck("mir", mir, 16'h3604);
			rk(8'h05, 8'h0A);
			rk(8'h02, 8'h84);
			$display("lock test done");
		end
	endtask
	task t_freeze;
		begin
			clk_en = 0;
			tfc_host_i.wr(8'h03, 8'h08);
			w2;
			clk_en = 1;
			w2;
			ck("mir", mir, 16'h3604);
			rk(8'h03, 8'h44);
			$display("freeze test done");
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d bad %0d", compares, error_cnt);
			if (error_cnt == 0 && compares > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		#1 rst = 0;
		t_reset;
		t_fields;
		t_events;
		t_rate;
		t_lock;
		t_freeze;
		complete_run;
	end
endmodule
